// >>> design/ps2_chan_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PS2_CHAN_CONSTS_SVH
`define PS2_CHAN_CONSTS_SVH

`define OFS_DATA 5'h00
`define OFS_CTRL 5'h04
`define OFS_STAT 5'h08
`define OFS_EVT 5'h0c
`define OFS_MASK 5'h10

`define RXB_RESET 8'hff

`define SB_RXV 0
`define SB_RXTO 1
`define SB_PAR 2
`define SB_FE 3
`define SB_TXIDLE 4
`define SB_TXTO 5
`define SB_RXBUSY 6
`define SB_STTO 7
`define STK_W1C 8'hae

`define EV_RX 0
`define EV_TX 1
`define EV_ERR 2

`define PAR_ODD 2'h0
`define PAR_EVEN 2'h1
`define PAR_NONE 2'h2
`define STOP_HIGH 2'h0
`define STOP_LOW 2'h1
`define STOP_NONE 2'h2

`define LAST_EDGE 4'ha
`define PAR_EDGE 4'h9

`define CLK_PERIOD_NS 25
`define BIT_GAP_US 300
`define START_WAIT_MS 25
`define PAR_WINDOW_MS 2
`define BIT_GAP_CYC (`BIT_GAP_US * 1000 / `CLK_PERIOD_NS)
`define START_WAIT_CYC (`START_WAIT_MS * 1000000 / `CLK_PERIOD_NS)
`define PAR_WINDOW_CYC (`PAR_WINDOW_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// >>> design/ps2_chan_pkg.sv
// Types shared by the line channel controller
package ps2_chan_pkg;
  typedef enum logic [2:0] {st_off, st_rx, st_tx_prep, st_tx, st_tx_to} chan_state_t;

  typedef struct packed {
    logic [1:0] stop_sel;
    logic [1:0] par_sel;
    logic channel_enable;
    logic direction_select;
  } ctrl_t;

  typedef struct packed {
    chan_state_t st;
    ctrl_t ctrl;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [10:0] shreg;
    logic [3:0] nbits;
    logic tx_pend;
    logic rx_valid;
    logic [7:0] stk;
    logic [2:0] ev;
    logic [2:0] mask;
    logic clk_prev;
    logic rd_seen;
    logic enter;
    logic ack;
    logic [31:0] rdata;
    logic clk_oe_n;
    logic dat_oe_n;
  } chan_st_t;

  typedef struct packed {
    logic [19:0] count;
  } tmr_st_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } sync_st_t;
endpackage

// >>> design/ps2_pin_sync.sv
// Two-stage synchroniser for the line clock and data pins
`timescale 1ns/1ps
module ps2_pin_sync import ps2_chan_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_sync
);
  sync_st_t s_q;
  sync_st_t s_d;

  always_comb begin
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= 4'hf;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.sync;
endmodule

// >>> design/ps2_timeout.sv
// Saturating timeout counter, expires after LIMIT running cycles
`timescale 1ns/1ps
module ps2_timeout import ps2_chan_pkg::*; #(
  parameter logic [19:0] LIMIT = 20'h00001
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic clear,
  output logic expired
);
  tmr_st_t t_q;
  tmr_st_t t_d;

  always_comb begin
    t_d = t_q;
    if (clear || !run) begin
      t_d.count = 20'h00000;
    end else if (t_q.count != LIMIT) begin
      t_d.count = t_q.count + 20'h00001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t_q <= 20'h00000;
    end else begin
      t_q <= t_d;
    end
  end

  assign expired = run && (t_q.count == LIMIT);
endmodule

// >>> design/ps2_host_channel.sv
// Function
// - Writing the transmit byte starts sending its low eight bits.
// - Each received byte lands in the low eight bits of receive byte.
// - Transmission waits until a pending received byte has been read.
// - Receive byte reloads to ffh after each read and after any timeout.
// - Stop field selects high, low or unchecked eleventh bit; 11b reserved.
// - Parity field selects odd, even or unchecked tenth bit; 11b reserved.
// - Stop and parity selections only matter while the channel is enabled.
// - Disabled channel idles, drives line clock low, releases line data.
// - Enabled channel runs reception or transmission automatically.
// - Direction bit zero means receive, one means transmit.
// - Data at 0h, control at 4h, status at 8h from the base.
// - Frame is start, eight data bits LSB first, parity, stop.
// - Valid byte holds line clock low until read; read clears and releases.
// - Transmit ends at eleventh edge or timeout; direction clears, idle.
// - Transmit timeout on 300us gap, 25ms start wait or 2ms to parity.
`timescale 1ns/1ps
`include "ps2_chan_consts.svh"
module ps2_host_channel import ps2_chan_pkg::*; #(
  parameter logic [19:0] GAP_CYC = 20'(`BIT_GAP_CYC),
  parameter logic [19:0] START_CYC = 20'(`START_WAIT_CYC),
  parameter logic [19:0] PAR_CYC = 20'(`PAR_WINDOW_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic line_clock_pin_in,
  output logic line_clock_pin_out,
  output logic line_clock_pin_oe_n,
  input wire logic line_data_pin_in,
  output logic line_data_pin_out,
  output logic line_data_pin_oe_n
);
  chan_st_t q;
  chan_st_t d;
  logic [1:0] pins;
  logic lclk;
  logic ldat;
  logic fall;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic gap_to;
  logic start_to;
  logic par_to;
  logic en;
  logic dir;
  logic tx_idle;
  logic rx_busy;
  logic [7:0] stat_rd;

  ps2_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({line_clock_pin_in, line_data_pin_in}),
    .pin_sync(pins)
  );

  assign lclk = pins[1];
  assign ldat = pins[0];
  assign fall = q.clk_prev && !lclk;

  ps2_timeout #(.LIMIT(GAP_CYC)) u_gap (
    .sys_clk(sys_clk),
    .rst(rst),
    .run((q.st == st_tx_to) || ((q.st == st_rx || q.st == st_tx) && q.nbits != 4'h0)),
    .clear(fall || q.enter),
    .expired(gap_to)
  );

  ps2_timeout #(.LIMIT(START_CYC)) u_start (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(q.st == st_tx && q.nbits == 4'h0),
    .clear(q.enter),
    .expired(start_to)
  );

  ps2_timeout #(.LIMIT(PAR_CYC)) u_par (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(q.st == st_tx && q.nbits != 4'h0 && q.nbits < `PAR_EDGE),
    .clear(q.enter),
    .expired(par_to)
  );

  assign en = q.ctrl.channel_enable;
  assign dir = q.ctrl.direction_select;
  assign tx_idle = (q.st != st_tx);
  assign rx_busy = (q.st == st_rx) && (q.nbits != 4'h0);
  assign stat_rd = {q.stk[`SB_STTO], rx_busy, q.stk[`SB_TXTO], tx_idle,
                    q.stk[`SB_FE], q.stk[`SB_PAR], q.stk[`SB_RXTO], q.rx_valid};

  // One wait state per access
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !q.ack;
  assign acc_wr = avs_write && q.ack && avs_byteenable[0];
  assign acc_rd = avs_read && q.ack;

  always_comb begin
    logic [10:0] frame;
    logic par_ok;
    logic stop_ok;
    frame = {ldat, q.shreg[10:1]};
    par_ok = (q.ctrl.par_sel[1]) || ((^frame[9:1]) == (q.ctrl.par_sel == `PAR_ODD));
    stop_ok = (q.ctrl.stop_sel[1]) || (frame[10] == (q.ctrl.stop_sel == `STOP_HIGH));
    d = q;
    d.clk_prev = lclk;
    d.ack = req && !q.ack;
    d.enter = 1'b0;

    if (req && !q.ack) begin
      case (avs_address)
        `OFS_DATA: d.rdata = {24'h000000, q.rx_byte};
        `OFS_CTRL: d.rdata = {26'h0000000, q.ctrl};
        `OFS_STAT: d.rdata = {24'h000000, stat_rd};
        `OFS_EVT: d.rdata = {29'h00000000, q.ev};
        `OFS_MASK: d.rdata = {29'h00000000, q.mask};
        default: d.rdata = 32'h00000000;
      endcase
    end

    if (acc_wr) begin
      case (avs_address)
        `OFS_DATA: begin
          if (en && dir && q.st == st_tx_prep && !q.tx_pend) begin
            d.tx_byte = avs_writedata[7:0];
            d.tx_pend = 1'b1;
          end
        end
        `OFS_CTRL: begin
          d.ctrl = avs_writedata[5:0];
          d.ctrl.direction_select = avs_writedata[0] && !q.stk[`SB_TXTO];
        end
        `OFS_STAT: d.stk = q.stk & ~(avs_writedata[7:0] & `STK_W1C);
        `OFS_EVT: d.ev = q.ev & ~avs_writedata[2:0];
        `OFS_MASK: d.mask = avs_writedata[2:0];
        default: ;
      endcase
    end

    if (acc_rd && avs_address == `OFS_DATA) begin
      d.rx_byte = `RXB_RESET;
      d.rx_valid = 1'b0;
    end
    if (acc_rd && avs_address == `OFS_STAT) begin
      d.rd_seen = 1'b1;
    end

    if (!en) begin
      d.st = st_off;
      d.nbits = 4'h0;
      d.tx_pend = 1'b0;
    end else begin
      unique case (q.st)
        st_off: begin
          d.st = dir ? st_tx_prep : st_rx;
          d.nbits = 4'h0;
        end
        st_rx: begin
          if (dir) begin
            d.st = st_tx_prep;
            d.nbits = 4'h0;
          end else if (fall && !q.rx_valid) begin
            d.shreg = frame;
            d.nbits = q.nbits + 4'h1;
            if (q.nbits == `LAST_EDGE) begin
              d.nbits = 4'h0;
              if (!frame[0] && par_ok && stop_ok) begin
                d.rx_byte = frame[8:1];
                d.rx_valid = 1'b1;
                d.ev[`EV_RX] = 1'b1;
              end else begin
                if (!par_ok) begin
                  d.stk[`SB_PAR] = 1'b1;
                end
                if (!stop_ok || frame[0]) begin
                  d.stk[`SB_FE] = 1'b1;
                  d.stk[`SB_RXTO] = 1'b1;
                end
                d.ev[`EV_ERR] = 1'b1;
              end
            end
          end else if (gap_to) begin
            d.nbits = 4'h0;
            d.stk[`SB_RXTO] = 1'b1;
            d.rx_byte = `RXB_RESET;
            d.ev[`EV_ERR] = 1'b1;
          end
        end
        st_tx_prep: begin
          if (!dir) begin
            d.st = st_rx;
          end else if (q.tx_pend && !q.rx_valid) begin
            d.st = st_tx;
            d.tx_pend = 1'b0;
            d.nbits = 4'h0;
            d.shreg = {1'b1, ~^q.tx_byte, q.tx_byte, 1'b0};
          end
        end
        st_tx: begin
          if (!dir) begin
            d.st = st_rx;
            d.ev[`EV_TX] = 1'b1;
          end else if (fall) begin
            d.shreg = {1'b1, q.shreg[10:1]};
            d.nbits = q.nbits + 4'h1;
            if (q.nbits == `LAST_EDGE) begin
              d.st = st_rx;
              d.nbits = 4'h0;
              d.ctrl.direction_select = 1'b0;
              d.ev[`EV_TX] = 1'b1;
            end
          end else if (start_to || gap_to || par_to) begin
            d.stk[`SB_TXTO] = 1'b1;
            d.stk[`SB_STTO] = q.stk[`SB_STTO] || start_to;
            d.st = st_tx_to;
            d.ctrl.direction_select = 1'b0;
            d.rd_seen = 1'b0;
            d.nbits = 4'h0;
            d.rx_byte = `RXB_RESET;
            d.ev[`EV_TX] = 1'b1;
            d.ev[`EV_ERR] = 1'b1;
          end
        end
        st_tx_to: begin
          // Clock held low 300us and until status read
          d.ctrl.direction_select = 1'b0;
          if (gap_to && q.rd_seen) begin
            d.st = st_rx;
          end
        end
      endcase
    end

    d.enter = (d.st != q.st);
    d.clk_oe_n = !(d.st == st_off || d.st == st_tx_prep || d.st == st_tx_to ||
                   (d.st == st_rx && d.rx_valid));
    d.dat_oe_n = !(d.st == st_tx && !d.shreg[0]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.rx_byte <= `RXB_RESET;
      q.clk_prev <= 1'b1;
      q.dat_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign irq = |(q.ev & q.mask);
  assign line_clock_pin_out = 1'b0;
  assign line_data_pin_out = 1'b0;
  assign line_clock_pin_oe_n = q.clk_oe_n;
  assign line_data_pin_oe_n = q.dat_oe_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_off;
    !en |=> (q.st == st_off) && !line_clock_pin_oe_n && line_data_pin_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel not parked");

  property p_reload;
    acc_rd && avs_address == `OFS_DATA && q.rx_valid |=> q.rx_byte == `RXB_RESET && !q.rx_valid;
  endproperty
  a_reload: assert property (p_reload) else $error("receive byte not reloaded");

  property p_hold_tx;
    q.rx_valid && q.st == st_tx_prep |=> q.st != st_tx;
  endproperty
  a_hold_tx: assert property (p_hold_tx) else $error("transmit started over valid byte");

  property p_clk_hold;
    en && !acc_rd && q.rx_valid && q.st == st_rx |=> !line_clock_pin_oe_n;
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("line clock not held");

  property p_tx_done;
    en && dir && q.st == st_tx && fall && q.nbits == `LAST_EDGE
      |=> q.st == st_rx && !q.ctrl.direction_select;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("transmit did not end");

  property p_start_to;
    en && dir && q.st == st_tx && start_to && !fall
      |=> q.st == st_tx_to && q.stk[`SB_TXTO] && q.stk[`SB_STTO] ##1 !line_clock_pin_oe_n;
  endproperty
  a_start_to: assert property (p_start_to) else $error("start timeout missed");

  property p_accept;
    acc_wr && avs_address == `OFS_DATA && en && dir && q.st == st_tx_prep && !q.tx_pend
      |=> q.tx_pend && q.tx_byte == $past(avs_writedata[7:0]);
  endproperty
  a_accept: assert property (p_accept) else $error("transmit byte lost");

  property p_store;
    $rose(q.rx_valid) |-> $past(fall) && $past(q.nbits) == `LAST_EDGE &&
      q.rx_byte == $past(q.shreg[9:2]);
  endproperty
  a_store: assert property (p_store) else $error("received byte wrong");

  property p_par;
    $rose(q.stk[`SB_PAR]) |-> !$past(q.ctrl.par_sel[1]) && $past(en);
  endproperty
  a_par: assert property (p_par) else $error("parity flagged while unchecked");

  property p_stop;
    $rose(q.stk[`SB_FE]) |-> $past(en) && $past(q.st) == st_rx;
  endproperty
  a_stop: assert property (p_stop) else $error("framing error out of receive");

  property p_dis_quiet;
    !en |=> !(q.stk[`SB_PAR] && !$past(q.stk[`SB_PAR]));
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("check while disabled");

  property p_dir;
    q.st == st_tx_prep |-> $past(dir);
  endproperty
  a_dir: assert property (p_dir) else $error("transmit mode without direction");

  property p_edge;
    q.nbits != $past(q.nbits) && q.nbits != 4'h0 |-> $past(fall);
  endproperty
  a_edge: assert property (p_edge) else $error("bit count moved without edge");

  property p_ctrl_rd;
    acc_rd && avs_address == `OFS_CTRL |-> avs_readdata[5:1] == q.ctrl[5:1];
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  c_rx: cover property ($rose(q.rx_valid));
  c_tx: cover property (q.st == st_tx ##1 q.st == st_rx);
  c_to: cover property ($rose(q.stk[`SB_TXTO]));
  c_irq: cover property ($rose(irq));
endmodule

// >>> verif/ps2_dev_model.sv
// Behavioural keyboard or mouse peer on the open-drain line pair
`timescale 1ns/1ps
module ps2_dev_model (
  input wire logic clk_oe_n,
  input wire logic dat_oe_n,
  output logic clk_line,
  output logic dat_line
);
  logic clk_low = 1'b0;
  logic dat_low = 1'b0;
  // Pull-ups: a line is low while any party sinks it
  assign clk_line = !(clk_low || !clk_oe_n);
  assign dat_line = !(dat_low || !dat_oe_n);
  // send start, data lsb first, parity, stop
  task automatic send(input logic [10:0] fr);
    int n;
    for (n = 0; n < 2000 && !clk_line; n++) #100;
    #7;
    for (n = 0; n < 11; n++) begin
      dat_low = !fr[n];
      #60 clk_low = 1'b1;
      #100 clk_low = 1'b0;
      #40;
    end
    dat_low = 1'b0;
  endtask
  // eleven clocks for a host frame, ack on the last
  task automatic recv(output logic [9:0] bits, output logic seen);
    int n;
    bits = '0;
    for (n = 0; n < 4000 && !(clk_line && !dat_line); n++) #25;
    seen = (n < 4000);
    if (seen) begin
      // Released clock must be seen high before the first fall
      #200;
      for (n = 1; n < 12; n++) begin
        dat_low = (n == 11);
        clk_low = 1'b1;
        #140;
        if (n < 11) bits[n-1] = dat_line;
        clk_low = 1'b0;
        #60;
      end
      dat_low = 1'b0;
    end
  endtask
endmodule

// >>> verif/ps2_host_channel_bench.sv
// Self-checking bench for the line channel controller
`timescale 1ns/1ps
module ps2_host_channel_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, clk_out, clk_oe_n, dat_out, dat_oe_n, clk_line, dat_line;
  int error_cnt = 0;
  int compares = 0;
  int seed = 62360;
  int i;
  logic [31:0] rd, j;
  logic [9:0] bits;
  logic [7:0] b;
  logic seen, p, s;

  initial forever #12.5 sys_clk = ~sys_clk;

  ps2_host_channel #(.GAP_CYC(20'h00028), .START_CYC(20'h00190), .PAR_CYC(20'h00190)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .line_clock_pin_in(clk_line), .line_clock_pin_out(clk_out),
    .line_clock_pin_oe_n(clk_oe_n), .line_data_pin_in(dat_line),
    .line_data_pin_out(dat_out), .line_data_pin_oe_n(dat_oe_n));

  ps2_dev_model i_peer (.clk_oe_n(clk_oe_n), .dat_oe_n(dat_oe_n), .clk_line(clk_line),
    .dat_line(dat_line));

  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let registered outputs settle before callers look at them
    @(negedge sys_clk);
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask

  // control changes spaced beyond 500 ns
  task automatic wr_ctrl(input logic [31:0] wd);
    bus_wr(5'h04, wd);
    repeat (20) @(posedge sys_clk);
  endtask

  // Parity error in bit 0, framing error in bit 1
  function automatic logic [1:0] exp_err(logic [7:0] d, logic pb, logic sb, logic [1:0] ps,
                                         logic [1:0] ss);
    logic pe, fe;
    pe = (ps == 2'h0 && !(^{d, pb})) || (ps == 2'h1 && (^{d, pb}));
    fe = (ss == 2'h0 && !sb) || (ss == 2'h1 && sb);
    return {fe, pe};
  endfunction

  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 5'h00, 32'h0, rd);
    check(rd, 32'h0000_00ff, "receive byte reset");
    bus(1'b0, 5'h04, 32'h0, rd);
    check(rd, 32'h0, "control reset");
    bus(1'b0, 5'h14, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    check(32'({clk_oe_n, dat_oe_n}), 32'h1, "disabled pins");
    check(32'({clk_out, dat_out}), 32'h0, "pins sink low");
    bus_wr(5'h10, 32'h1);
    wr_ctrl(32'h2);
    check(32'({clk_oe_n, dat_oe_n}), 32'h3, "receive idle floats");
    b = 8'($random(seed));
    i_peer.send({1'b1, ~^b, b, 1'b0});
    repeat (10) @(posedge sys_clk);
    check(32'({irq, clk_oe_n}), 32'h2, "byte held, clock low");
    bus_wr(5'h10, 32'h0);
    check(32'(irq), 32'h0, "masked event");
    bus_wr(5'h10, 32'h1);
    bus(1'b0, 5'h00, 32'h0, rd);
    check(rd, {24'h0, b}, "received byte");
    bus(1'b0, 5'h00, 32'h0, rd);
    check(rd, 32'h0000_00ff, "reload after read");
    repeat (3) @(posedge sys_clk);
    check(32'(clk_oe_n), 32'h1, "clock released");
    bus_wr(5'h0c, 32'h7);
    check(32'(irq), 32'h0, "event cleared");
    // Every stop and parity selection, random frame contents
    for (i = 0; i < 16; i++) begin
      wr_ctrl({26'h0, 4'(i), 2'h2});
      b = 8'($random(seed));
      p = 1'($random(seed));
      s = 1'($random(seed));
      i_peer.send({s, p, b, 1'b0});
      repeat (10) @(posedge sys_clk);
      bus(1'b0, 5'h08, 32'h0, rd);
      check(32'(rd[3:2]), 32'(exp_err(b, p, s, 2'(i), 2'(i >> 2))), "frame check");
      bus_wr(5'h08, 32'hff);
      bus(1'b0, 5'h00, 32'h0, rd);
      bus_wr(5'h0c, 32'h7);
    end
    // Transmit requested while a received byte waits
    wr_ctrl(32'h2);
    b = 8'($random(seed));
    i_peer.send({1'b1, ~^b, b, 1'b0});
    repeat (10) @(posedge sys_clk);
    wr_ctrl(32'h3);
    j = $random(seed);
    bus_wr(5'h00, {24'h0, j[7:0]});
    repeat (20) @(posedge sys_clk);
    check(32'(dat_oe_n), 32'h1, "transmit held off");
    bus(1'b0, 5'h00, 32'h0, rd);
    check(rd, {24'h0, b}, "pending byte");
    i_peer.recv(bits, seen);
    check(32'(seen), 32'h1, "transmit started");
    check(32'(bits), 32'({1'b1, ~^j[7:0], j[7:0]}), "sent frame");
    repeat (10) @(posedge sys_clk);
    bus(1'b0, 5'h04, 32'h0, rd);
    check(rd, 32'h2, "direction cleared");
    bus(1'b0, 5'h08, 32'h0, rd);
    check(32'(rd[4]), 32'h1, "transmitter idle");
    // No peer clocks: start wait runs out
    wr_ctrl(32'h3);
    bus_wr(5'h00, $random(seed));
    rd = 32'h0;
    for (i = 0; i < 400 && rd[5] !== 1'b1; i++) bus(1'b0, 5'h08, 32'h0, rd);
    check(32'(rd[5]), 32'h1, "transmit timeout");
    bus(1'b0, 5'h04, 32'h0, rd);
    check(rd, 32'h2, "direction cleared on timeout");
    bus(1'b0, 5'h00, 32'h0, rd);
    check(rd, 32'h0000_00ff, "reload after timeout");
    bus_wr(5'h08, 32'hff);
    wr_ctrl(32'h0);
    check(32'({clk_oe_n, dat_oe_n}), 32'h1, "disabled again");
    report_and_stop();
  end
endmodule
